// File: rtl/fcs_defs.svh
// Constants for the flash program and erase status engine
//
// Contract
// - Erase-window bit stays 0 for the window
// - Window bit goes 1 on expiry or next sector
// - Only sector or whole-array erase, no byte erase
// - Erased byte reads ff, programming clears bits
// - Program one byte, erase whole sectors
// - Status by polling bit, toggle bit, ready pin
// - Programming read returns inverted bit 7 of data
// - Error on program timeout or zero-to-one attempt
// - Polling bit reads 0 until erase completes
// - Any address in erased sector gives status
// - Status valid after fourth or sixth write
// - Error bit cleared only by reset instruction
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ==========================================================
// Clock and timing
`define FCS_CLK_NS        40
`define FCS_WIN_TIME_US   100
`define FCS_WIN_TOL_PCT   20
`define FCS_WIN_CYCLES    ((`FCS_WIN_TIME_US * 1000) / `FCS_CLK_NS)
`define FCS_PROG_CYCLES   16
`define FCS_PROG_TOUT     64
`define FCS_ERASE_TOUT    1024

// ==========================================================
// Array geometry
`define FCS_ADDR_W        8
`define FCS_DEPTH         256
`define FCS_SECT_MSB      7
`define FCS_SECT_LSB      6
`define FCS_ERASED        8'hff

// ==========================================================
// Instruction data bytes
`define FCS_CMD_UNLOCK1   8'haa
`define FCS_CMD_UNLOCK2   8'h55
`define FCS_CMD_PROGRAM   8'ha0
`define FCS_CMD_ERASE     8'h80
`define FCS_CMD_SECTOR    8'h30
`define FCS_CMD_BULK      8'h10
`define FCS_CMD_RESET     8'hf0

// ==========================================================
// Status byte fields
`define FCS_POLL_BIT      7
`define FCS_TOGGLE_BIT    6
`define FCS_ERROR_BIT     5
`define FCS_WIN_BIT       3

`endif

// File: rtl/fcs_pkg.sv
// Types shared by the flash status engine
`default_nettype none

package fcs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG,
    ST_WIN,
    ST_ERASE,
    ST_FAIL
  } fcs_state_e;

  typedef struct packed {
    fcs_state_e  state;
    logic [2:0]  seq;
    logic [7:0]  prog_addr;
    logic [7:0]  prog_data;
    logic [3:0]  mask;
    logic [7:0]  erase_addr;
    logic [11:0] cnt;
    logic [11:0] tout;
    logic        is_erase;
    logic        error;
    logic        toggle;
    logic        win;
    logic        ready;
    logic [7:0]  rdata;
    logic        stuck_meta;
    logic        stuck;
  } fcs_regs_s;

endpackage
`default_nettype wire

// File: rtl/fcs_flash_array.sv
// Byte-wide flash cell array with one port whose single address serves both reads and writes
`include "fcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module fcs_flash_array (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Access port
  input  wire logic [`FCS_ADDR_W-1:0] addr,
  input  wire logic                   we,
  input  wire logic [7:0]             wdata,
  output logic      [7:0]             rdata
);

  logic [7:0] mem [`FCS_DEPTH];

  // ==========================================================
  // Cells
  // Reset stands in for a fresh, fully erased part
  genvar i;
  generate
    for (i = 0; i < `FCS_DEPTH; i++) begin : g_cell
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          mem[i] <= `FCS_ERASED;
        end else if (we && (addr == i[`FCS_ADDR_W-1:0])) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

  assign rdata = mem[addr];

endmodule
`default_nettype wire

// File: rtl/fcs_status_engine.sv
// Flash program and erase engine with polled status reporting
//
// Chosen here: the plain strobed port and the address map.
`include "fcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module fcs_status_engine (
  // Clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   RESET_N,
  // Microcontroller bus
  input  wire logic [`FCS_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]             WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [7:0]             RDATA,
  // Flash cell health, asynchronous
  input  wire logic                   ARRAY_STUCK,
  // Ready/busy status
  output logic                        READY
);

  // ==========================================================
  // Local constants
  localparam logic [11:0] WIN_LAST   = 12'(`FCS_WIN_CYCLES - 1);
  localparam logic [11:0] PROG_LAST  = 12'(`FCS_PROG_CYCLES - 1);
  localparam logic [11:0] PTOUT_LAST = 12'(`FCS_PROG_TOUT - 1);
  localparam logic [11:0] ETOUT_LAST = 12'(`FCS_ERASE_TOUT - 1);
  localparam logic [7:0]  LAST_ADDR  = 8'(`FCS_DEPTH - 1);

  // ==========================================================
  // State
  fcs_pkg::fcs_regs_s r;
  fcs_pkg::fcs_regs_s next_r;

  // Array port
  logic [`FCS_ADDR_W-1:0] arr_addr;
  logic                   arr_we;
  logic [7:0]             arr_wdata;
  logic [7:0]             arr_rdata;

  // Derived status
  logic       busy;
  logic       poll_bit;
  logic [7:0] status_byte;
  logic [1:0] wr_sector;
  logic [3:0] wr_sector_bit;
  logic [1:0] er_sector;

  // ==========================================================
  // Cell array
  fcs_flash_array u_array (
    .clk     (REF_CLK),
    .reset_n (RESET_N),
    .addr    (arr_addr),
    .we      (arr_we),
    .wdata   (arr_wdata),
    .rdata   (arr_rdata)
  );

  // ==========================================================
  // Sector decode
  assign wr_sector     = ADDR[`FCS_SECT_MSB:`FCS_SECT_LSB];
  assign wr_sector_bit = 4'h1 << wr_sector;
  assign er_sector     = r.erase_addr[`FCS_SECT_MSB:`FCS_SECT_LSB];

  // ==========================================================
  // Status byte
  assign busy = (r.state != fcs_pkg::ST_IDLE);

  always_comb begin
    if (r.is_erase) begin
      poll_bit = 1'b0;
    end else begin
      poll_bit = ~r.prog_data[7];
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[`FCS_POLL_BIT]   = poll_bit;
    status_byte[`FCS_TOGGLE_BIT] = r.toggle;
    status_byte[`FCS_ERROR_BIT]  = r.error;
    status_byte[`FCS_WIN_BIT]    = r.win;
  end

  // ==========================================================
  // Array port steering
  // Erase walks the array one byte a cycle, so the read port
  // follows the walk and bus reads see status instead.
  always_comb begin
    case (r.state)
      fcs_pkg::ST_PROG: begin
        arr_addr = r.prog_addr;
      end
      fcs_pkg::ST_ERASE: begin
        arr_addr = r.erase_addr;
      end
      default: begin
        arr_addr = ADDR;
      end
    endcase
  end

  always_comb begin
    arr_we    = 1'b0;
    arr_wdata = arr_rdata;
    case (r.state)
      fcs_pkg::ST_PROG: begin
        if (!r.stuck && (r.cnt == PROG_LAST)) begin
          arr_we    = 1'b1;
          arr_wdata = arr_rdata & r.prog_data;
        end
      end
      fcs_pkg::ST_ERASE: begin
        if (!r.stuck && r.mask[er_sector]) begin
          arr_we    = 1'b1;
          arr_wdata = `FCS_ERASED;
        end
      end
      default: begin
        arr_we    = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;

    // Two-stage synchroniser for the health pin
    next_r.stuck_meta = ARRAY_STUCK;
    next_r.stuck      = r.stuck_meta;

    // Bus reads; each status read flips the toggle bit
    if (RD) begin
      if (busy) begin
        next_r.rdata  = status_byte;
        next_r.toggle = ~r.toggle;
      end else begin
        next_r.rdata  = arr_rdata;
      end
    end

    case (r.state)
      // --------------------------------------------------
      fcs_pkg::ST_IDLE: begin
        next_r.win  = 1'b1;
        next_r.cnt  = 12'h000;
        next_r.tout = 12'h000;
        if (WR) begin
          if (WDATA == `FCS_CMD_RESET) begin
            next_r.seq = 3'h0;
          end else begin
            next_r.seq = 3'h0;
            case (r.seq)
              3'h0: begin
                if (WDATA == `FCS_CMD_UNLOCK1) begin
                  next_r.seq = 3'h1;
                end
              end
              3'h1: begin
                if (WDATA == `FCS_CMD_UNLOCK2) begin
                  next_r.seq = 3'h2;
                end
              end
              3'h2: begin
                if (WDATA == `FCS_CMD_PROGRAM) begin
                  next_r.seq = 3'h3;
                end else if (WDATA == `FCS_CMD_ERASE) begin
                  next_r.seq = 3'h4;
                end
              end
              3'h3: begin
                // Fourth write: one byte, status live from here
                next_r.prog_addr = ADDR;
                next_r.prog_data = WDATA;
                next_r.is_erase  = 1'b0;
                next_r.ready     = 1'b0;
                if ((WDATA & ~arr_rdata) != 8'h00) begin
                  next_r.state = fcs_pkg::ST_FAIL;
                  next_r.error = 1'b1;
                end else begin
                  next_r.state = fcs_pkg::ST_PROG;
                end
              end
              3'h4: begin
                if (WDATA == `FCS_CMD_UNLOCK1) begin
                  next_r.seq = 3'h5;
                end
              end
              3'h5: begin
                if (WDATA == `FCS_CMD_UNLOCK2) begin
                  next_r.seq = 3'h6;
                end
              end
              3'h6: begin
                // Sixth write: only sector or bulk erase exist
                next_r.is_erase   = 1'b1;
                next_r.erase_addr = 8'h00;
                if (WDATA == `FCS_CMD_SECTOR) begin
                  next_r.mask  = wr_sector_bit;
                  next_r.win   = 1'b0;
                  next_r.ready = 1'b0;
                  next_r.state = fcs_pkg::ST_WIN;
                end else if (WDATA == `FCS_CMD_BULK) begin
                  next_r.mask  = 4'hf;
                  next_r.ready = 1'b0;
                  next_r.state = fcs_pkg::ST_ERASE;
                end
              end
              default: begin
                next_r.seq = 3'h0;
              end
            endcase
          end
        end
      end

      // --------------------------------------------------
      fcs_pkg::ST_PROG: begin
        // Writes are ignored while the byte is being programmed
        next_r.tout = r.tout + 12'h001;
        if (!r.stuck) begin
          next_r.cnt = r.cnt + 12'h001;
        end
        if (!r.stuck && (r.cnt == PROG_LAST)) begin
          next_r.state = fcs_pkg::ST_IDLE;
          next_r.ready = 1'b1;
        end else if (r.tout == PTOUT_LAST) begin
          next_r.state = fcs_pkg::ST_FAIL;
          next_r.error = 1'b1;
        end
      end

      // --------------------------------------------------
      fcs_pkg::ST_WIN: begin
        next_r.cnt = r.cnt + 12'h001;
        next_r.win = 1'b0;
        if (WR) begin
          if (WDATA == `FCS_CMD_SECTOR) begin
            // A further sector closes the window at once
            next_r.mask  = r.mask | wr_sector_bit;
            next_r.win   = 1'b1;
            next_r.cnt   = 12'h000;
            next_r.state = fcs_pkg::ST_ERASE;
          end else begin
            // Any other instruction aborts back to array reads
            next_r.win   = 1'b1;
            next_r.ready = 1'b1;
            next_r.seq   = 3'h0;
            next_r.state = fcs_pkg::ST_IDLE;
          end
        end else if (r.cnt == WIN_LAST) begin
          next_r.win   = 1'b1;
          next_r.cnt   = 12'h000;
          next_r.state = fcs_pkg::ST_ERASE;
        end
      end

      // --------------------------------------------------
      fcs_pkg::ST_ERASE: begin
        // Extra sector writes here are too late and ignored
        next_r.win  = 1'b1;
        next_r.tout = r.tout + 12'h001;
        if (!r.stuck) begin
          next_r.erase_addr = r.erase_addr + 8'h01;
        end
        if (!r.stuck && (r.erase_addr == LAST_ADDR)) begin
          next_r.state = fcs_pkg::ST_IDLE;
          next_r.ready = 1'b1;
        end else if (r.tout == ETOUT_LAST) begin
          next_r.state = fcs_pkg::ST_FAIL;
          next_r.error = 1'b1;
        end
      end

      // --------------------------------------------------
      fcs_pkg::ST_FAIL: begin
        // Only the reset instruction leaves the failed state
        if (WR && (WDATA == `FCS_CMD_RESET)) begin
          next_r.error = 1'b0;
          next_r.ready = 1'b1;
          next_r.seq   = 3'h0;
          next_r.state = fcs_pkg::ST_IDLE;
        end
      end

      // --------------------------------------------------
      default: begin
        next_r.state = fcs_pkg::ST_IDLE;
        next_r.ready = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      r.state      <= fcs_pkg::ST_IDLE;
      r.seq        <= 3'h0;
      r.prog_addr  <= 8'h00;
      r.prog_data  <= 8'h00;
      r.mask       <= 4'h0;
      r.erase_addr <= 8'h00;
      r.cnt        <= 12'h000;
      r.tout       <= 12'h000;
      r.is_erase   <= 1'b0;
      r.error      <= 1'b0;
      r.toggle     <= 1'b0;
      r.win        <= 1'b1;
      r.ready      <= 1'b1;
      r.rdata      <= 8'h00;
      r.stuck_meta <= 1'b0;
      r.stuck      <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign RDATA = r.rdata;
  assign READY = r.ready;

endmodule
`default_nettype wire

// File: test/fcs_status_chk.sv
// Port assertions for the flash status engine
`timescale 1ns/100ps
`default_nettype none

module fcs_status_chk (
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       RESET_N,
  // Host bus
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Status
  input wire logic       ARRAY_STUCK,
  input wire logic       READY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  // ==========================================================
  // Instruction shapes, only counted while the engine is idle
  sequence s_w(logic [7:0] d);
    WR && WDATA == d && READY;
  endsequence
  sequence s_unl;
    s_w(8'haa) ##1 s_w(8'h55);
  endsequence
  sequence s_ers(logic [7:0] d);
    s_unl ##1 s_w(8'h80) ##1 s_unl ##1 s_w(d);
  endsequence
  sequence s_prog;
    s_unl ##1 s_w(8'ha0) ##1 WR && READY;
  endsequence

  // ==========================================================
  // Assertions
  reset_vals_a: assert property ($rose(RESET_N) |-> READY && !RDATA)
    else $error("bad values after reset");
  prog_busy_a: assert property (s_prog |=> !READY)
    else $error("program did not go busy");
  poll_inv_a: assert property (s_prog ##1 RD |=>
    RDATA[7] == !$past(WDATA[7], 2)) else $error("polling bit not inverted");
  win_open_a: assert property (s_ers(8'h30) ##1 RD |=>
    !RDATA[3] && !RDATA[7]) else $error("window bit not low");
  // The engine is busy once the window opens, so no READY term here
  win_close_a: assert property (s_ers(8'h30) ##1 (WR && WDATA == 8'h30)
    ##1 RD |=>
    RDATA[3] && !RDATA[7]) else $error("window bit not set");
  bulk_busy_a: assert property (s_ers(8'h10) ##1 RD |=>
    RDATA[3] && !RDATA[7] && !READY) else $error("bulk status wrong");
  err_hold_a: assert property ($past(RD, 2) && !$past(READY, 2) &&
    !$past(WR) && RDATA[5] && RD && !READY |=> RDATA[5])
    else $error("error bit dropped");
  err_clear_a: assert property (RDATA[5] && !READY &&
    WR && WDATA == 8'hf0 |-> ##2 READY) else $error("reset left fail");

  cover property (s_prog ##1 RD);
  cover property (s_ers(8'h30) ##1 (WR && WDATA == 8'h30));
  cover property ((RD && !READY) ##1 RDATA[5]);
endmodule

bind fcs_status_engine fcs_status_chk i_fcs_status_chk (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .ARRAY_STUCK(ARRAY_STUCK),
  .READY(READY));
`default_nettype wire

// File: test/fcs_host.sv
// Microcontroller bus model driving the flash status engine
`timescale 1ns/100ps
`default_nettype none

module fcs_host (
  // Clock
  input  wire logic       clk,
  // Bus towards the engine
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
  endtask

  // Released data lines must not keep showing the last byte
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= ~wdata;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~wdata;
  endtask

  task automatic unl;
    wr_byte(8'h00, 8'haa);
    wr_byte(8'h00, 8'h55);
  endtask

  // Caller erases first: programming only clears bits
  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    unl();
    wr_byte(8'h00, 8'ha0);
    wr_byte(a, d);
  endtask

  task automatic erase(input logic [7:0] a, input logic [7:0] c);
    unl();
    wr_byte(8'h00, 8'h80);
    unl();
    wr_byte(a, c);
  endtask

  // Result 0 done, 1 failure reported, 2 never settled
  task automatic poll(input logic [7:0] a, input logic [7:0] d,
                      output int res);
    logic [7:0] s;
    res = 2;
    for (int i = 0; i < 2000 && res == 2; i++) begin
      rd_byte(a, s);
      // Unknown status bits must never pass as done
      if (s[5] !== 1'b0) begin
        rd_byte(a, s);
        res = (s[7] === d[7]) ? 0 : 1;
      end else if (s[7] === d[7]) begin
        res = 0;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: test/flash_program_erase_status_bench.sv
// Self-checking bench for the flash program and erase status engine
`timescale 1ns/100ps
`default_nettype none

module flash_program_erase_status_bench;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       array_stuck = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       ready;
  int         failures = 0;
  int         cmp_count = 0;
  logic [7:0] row_addr [4] = '{8'h05, 8'h05, 8'h46, 8'hff};
  logic [7:0] row_data [4] = '{8'ha5, 8'h21, 8'h3c, 8'h00};
  logic [7:0] row_exp  [4] = '{8'ha5, 8'h21, 8'h3c, 8'h00};

  always #20 ref_clk = ~ref_clk;

  fcs_status_engine i_fcs_status_engine (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .ARRAY_STUCK(array_stuck),
    .READY(ready));
  fcs_host i_fcs_host (.clk(ref_clk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A poll that never settles ends the run at once
  task automatic do_poll(input logic [7:0] a, input logic [7:0] d,
                         input int exp, input string what);
    int r;
    i_fcs_host.poll(a, d, r);
    check(8'(r), 8'(exp), what);
    if (r == 2) print_verdict();
  endtask

  task automatic clear_fail;
    i_fcs_host.wr_byte(8'h00, 8'hf0);
    i_fcs_host.idle();
    @(posedge ref_clk);
    #1 check({7'h00, ready}, 8'h01, "ready after reset command");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] s;
    i_fcs_host.rd_byte(a, s);
    check(s, exp, "array byte");
  endtask

  initial begin
    logic [7:0] s;
    realtime    t0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1 check({7'h00, ready}, 8'h01, "ready after reset");
    check(rdata, 8'h00, "read data after reset");
    rd_chk(8'h05, 8'hff);
    $display("Test reset done");

    for (int i = 0; i < 4; i++) begin
      i_fcs_host.prog(row_addr[i], row_data[i]);
      do_poll(row_addr[i], row_data[i], 0, "program poll");
      rd_chk(row_addr[i], row_exp[i]);
    end
    rd_chk(8'h06, 8'hff);
    $display("Test program rows done");

    i_fcs_host.prog(8'h46, 8'hff);
    do_poll(8'h46, 8'hff, 1, "zero to one poll");
    clear_fail();
    rd_chk(8'h46, 8'h3c);
    $display("Test zero to one done");

    i_fcs_host.erase(8'h46, 8'h30);
    i_fcs_host.wr_byte(8'h05, 8'h30);
    do_poll(8'h7f, 8'hff, 0, "two sector erase");
    rd_chk(8'h46, 8'hff);
    rd_chk(8'h05, 8'hff);
    rd_chk(8'hff, 8'h00);
    $display("Test two sectors done");

    i_fcs_host.erase(8'hff, 8'h30);
    t0 = $realtime;
    i_fcs_host.rd_byte(8'hc0, s);
    check(s & 8'h88, 8'h00, "window open status");
    repeat (2400) @(posedge ref_clk);
    i_fcs_host.rd_byte(8'hd3, s);
    check(s & 8'h08, 8'h00, "window still open");
    do_poll(8'hc0, 8'hff, 0, "window erase");
    check(8'(($realtime - t0) >= 100000.0 && ($realtime - t0) < 135000.0),
          8'h01, "window length");
    rd_chk(8'hff, 8'hff);
    $display("Test erase window done");

    // A programmed byte in sector 2 shows that bulk erase reaches it
    i_fcs_host.prog(8'h85, 8'h5a);
    do_poll(8'h85, 8'h5a, 0, "program before bulk");
    @(posedge ref_clk);
    array_stuck <= 1'b1;
    i_fcs_host.prog(8'h86, 8'h0f);
    do_poll(8'h86, 8'h0f, 1, "stuck program");
    clear_fail();
    rd_chk(8'h86, 8'hff);
    i_fcs_host.erase(8'h00, 8'h10);
    do_poll(8'h00, 8'hff, 1, "stuck bulk erase");
    @(posedge ref_clk);
    array_stuck <= 1'b0;
    clear_fail();
    i_fcs_host.erase(8'h00, 8'h10);
    do_poll(8'h3f, 8'hff, 0, "bulk erase");
    rd_chk(8'h85, 8'hff);
    $display("Test bulk erase done");
    print_verdict();
  end
endmodule
`default_nettype wire
